// ==== rtl/bl_defines.svh ====
// Purpose: Constants of the serial-memory boot loader.
// Assumes: 50 MHz core clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef BL_DEFINES_SVH
`define BL_DEFINES_SVH

// -----------------------------------------------------------------------------
// Clocking and times
// -----------------------------------------------------------------------------
`define BL_CLK_HZ        50000000
`define BL_CLK_MHZ       50
`define BL_BOOST_HZ      250000
`define BL_BOOST_HALF    (`BL_CLK_HZ / (2 * `BL_BOOST_HZ))
`define BL_WAIT_US       500
`define BL_WAIT_CYC      (`BL_WAIT_US * `BL_CLK_MHZ)
`define BL_BLINK_HALF_MS 500
`define BL_BLINK_CYC     (`BL_BLINK_HALF_MS * 1000 * `BL_CLK_MHZ)
`define BL_BLINK_COUNT   3
`define BL_SPI_HALF      4

// -----------------------------------------------------------------------------
// Addresses, commands and codes
// -----------------------------------------------------------------------------
`define BL_ROM_VEC       16'hf840
`define BL_CMD_READ      8'h03
`define BL_FMT_ADDR      24'h000000
`define BL_BOOT_ADDR     24'h000002
`define BL_OVL_BASE      24'h000800
`define BL_FMT_A16       16'h0010
`define BL_FMT_A24       16'h0018

`endif

// ==== rtl/bl_pkg.sv ====
// Purpose: Types of the serial-memory boot loader.
// Assumes: Nothing.
// Notes:   Constants live in bl_defines.svh.
package bl_pkg;

	typedef enum logic [8:0] {
		ST_SUC   = 9'h001,
		ST_VEC   = 9'h002,
		ST_WAIT  = 9'h004,
		ST_CMD   = 9'h008,
		ST_DATA  = 9'h010,
		ST_END   = 9'h020,
		ST_RUN   = 9'h040,
		ST_BLINK = 9'h080,
		ST_SLEEP = 9'h100
	} bl_state_e;

	typedef enum logic [3:0] {
		PH_FMT = 4'h1,
		PH_HDR = 4'h2,
		PH_PAY = 4'h4,
		PH_TRL = 4'h8
	} bl_phase_e;

endpackage

// ==== rtl/bl_spi_if.sv ====
// Purpose: Byte request and answer between the loader and its shift engine.
// Assumes: Both ends on core_clk.
// Notes:   start is a one-cycle pulse; done is a one-cycle pulse with rx valid.
`timescale 1ns/10ps
`default_nettype none
interface bl_spi_if;
	logic       start;
	logic [7:0] tx;
	logic       done;
	logic [7:0] rx;

	modport ctrl   (output start, output tx, input done, input rx);
	modport engine (input start, input tx, output done, output rx);
endinterface
`default_nettype wire

// ==== rtl/bl_spi_byte.sv ====
// Purpose: Shifts one byte out and in on the serial memory link, mode 0.
// Assumes: miso is already synchronised to core_clk.
// Notes:   Most significant bit first; data sampled on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
`include "bl_defines.svh"
module bl_spi_byte #(
	parameter int HALF = `BL_SPI_HALF
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	bl_spi_if.engine  spi,
	input  wire logic miso,
	output logic      sclk,
	output logic      mosi
);
	logic       busy_reg;
	logic [7:0] tx_sh_reg;
	logic [7:0] rx_sh_reg;
	logic [7:0] cnt_reg;
	logic [2:0] bits_reg;

	assign spi.rx = rx_sh_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_reg  <= 1'b0;
			tx_sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			cnt_reg   <= 8'h00;
			bits_reg  <= 3'h0;
			sclk      <= 1'b0;
			mosi      <= 1'b0;
			spi.done  <= 1'b0;
		end else begin
			spi.done <= 1'b0;
			if (!busy_reg) begin
				if (spi.start) begin
					busy_reg  <= 1'b1;
					tx_sh_reg <= spi.tx;
					mosi      <= spi.tx[7];
					cnt_reg   <= 8'h00;
					bits_reg  <= 3'h0;
				end
			end else if (cnt_reg == 8'(HALF - 1)) begin
				cnt_reg <= 8'h00;
				if (!sclk) begin
					sclk      <= 1'b1;
					rx_sh_reg <= {rx_sh_reg[6:0], miso};
				end else begin
					sclk <= 1'b0;
					if (bits_reg == 3'h7) begin
						busy_reg <= 1'b0;
						spi.done <= 1'b1;
					end else begin
						bits_reg  <= bits_reg + 3'h1;
						tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
						mosi      <= tx_sh_reg[6];
					end
				end
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end
	end
endmodule // bl_spi_byte
`default_nettype wire

// ==== rtl/bl_boot_loader.sv ====
// Purpose: Boot sequencer that powers a serial memory and loads a container.
// Assumes: ROM, RAM write port and debug inputs share core_clk; miso does not.
// Notes:   One container is loaded at boot; further ones on overlay request.
// Functional notes
// - Drive a 250 kHz boost clock from loader initialisation until the initial load ends.
// - Wait about 500 us after boost clock start before reading memory.
// - Verify container checksum; start application only when it matches.
// - Fetch loader entry from the 16-bit pointer at ROM address 0xF840.
// - Startup firmware initialises, checks integrity, then branches to loader.
// - Support one-bit serial memories with 16-bit or 24-bit addresses.
// - Read format indicator at 0x0 and 0x1; set address width accordingly.
// - Container from below 0x800: LED off and password check with stop.
// - Container from 0x800 upward leaves the LED supply untouched.
// - LED in the memory supply path lights briefly during loading.
// - Leave the serial memory inactive after the initial load.
// - Valid debug password on locked parts sends device to deepest sleep.
// - Header holds length, destination and start address, 16 bits each.
// - Payload is even length; odd length padded with one zero byte.
// - Trailer holds two checksum copies, word XOR from zero.
// - Absent memory or load error: blink LED three times, then sleep.
`timescale 1ns/10ps
`default_nettype none
`include "bl_defines.svh"
module bl_boot_loader #(
	parameter int WAIT_CYC  = `BL_WAIT_CYC,
	parameter int BLINK_CYC = `BL_BLINK_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        suc_done,
	input  wire logic        suc_ok,
	input  wire logic        dbg_locked,
	input  wire logic        dbg_pw_valid,
	output logic      [15:0] rom_addr,
	input  wire logic [15:0] rom_data,
	output logic      [15:0] loader_entry,
	output logic             boost_clk,
	output logic             led_on,
	output logic             spi_cs_n,
	output logic             spi_sclk,
	output logic             spi_mosi,
	input  wire logic        spi_miso,
	output logic             ram_we,
	output logic      [15:0] ram_addr,
	output logic      [15:0] ram_wdata,
	input  wire logic        ovl_req,
	input  wire logic [23:0] ovl_addr,
	output logic             app_start,
	output logic      [15:0] app_addr,
	output logic             ovl_done,
	output logic             load_error,
	output logic             deep_sleep
);
	bl_pkg::bl_state_e state_reg;
	bl_pkg::bl_phase_e phase_reg;
	bl_spi_if          spi ();

	logic        miso_s1_reg;
	logic        miso_s2_reg;
	logic        boost_en_reg;
	logic [7:0]  boost_cnt_reg;
	logic [31:0] tmr_reg;
	logic [2:0]  blink_reg;
	logic        wait_ans_reg;
	logic [2:0]  idx_reg;
	logic [23:0] rd_addr_reg;
	logic        a24_reg;
	logic        cont_low_reg;
	logic        hi_reg;
	logic [7:0]  lo_reg;
	logic [1:0]  wcnt_reg;
	logic [15:0] words_reg;
	logic [15:0] dest_reg;
	logic [15:0] csum_reg;
	logic [15:0] trl0_reg;
	logic [15:0] word;

	assign word = {spi.rx, lo_reg};

	function automatic logic [7:0] cmd_byte(input logic [2:0] idx, input logic [23:0] a,
		input logic w24);
		logic [7:0] b;
		b = a[7:0];
		case (idx)
			3'h0: b = `BL_CMD_READ;
			3'h1: b = w24 ? a[23:16] : a[15:8];
			3'h2: b = w24 ? a[15:8] : a[7:0];
			default: b = a[7:0];
		endcase
		return b;
	endfunction

	// -------------------------------------------------------------------------
	// Link input synchroniser and byte engine
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
		end else begin
			miso_s1_reg <= spi_miso;
			miso_s2_reg <= miso_s1_reg;
		end
	end

	bl_spi_byte #(.HALF(`BL_SPI_HALF)) u_spi (
		.core_clk (core_clk),
		.resetn   (resetn),
		.spi      (spi.engine),
		.miso     (miso_s2_reg),
		.sclk     (spi_sclk),
		.mosi     (spi_mosi)
	);

	// -------------------------------------------------------------------------
	// Boost clock and LED
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			boost_cnt_reg <= 8'h00;
			boost_clk     <= 1'b0;
		end else if (!boost_en_reg) begin
			boost_cnt_reg <= 8'h00;
			boost_clk     <= 1'b0;
		end else if (boost_cnt_reg == 8'(`BL_BOOST_HALF - 1)) begin
			boost_cnt_reg <= 8'h00;
			boost_clk     <= ~boost_clk;
		end else begin
			boost_cnt_reg <= boost_cnt_reg + 8'h01;
		end
	end

	// The LED sits in the memory supply, so it glows while the boost runs.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			led_on <= 1'b0;
		end else if (state_reg == bl_pkg::ST_BLINK) begin
			led_on <= blink_reg[0];
		end else begin
			led_on <= boost_en_reg;
		end
	end

	// -------------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= bl_pkg::ST_SUC;
			phase_reg    <= bl_pkg::PH_FMT;
			rom_addr     <= `BL_ROM_VEC;
			loader_entry <= 16'h0000;
			boost_en_reg <= 1'b0;
			tmr_reg      <= 32'h0;
			blink_reg    <= 3'h0;
			spi_cs_n     <= 1'b1;
			spi.start    <= 1'b0;
			spi.tx       <= 8'h00;
			wait_ans_reg <= 1'b0;
			idx_reg      <= 3'h0;
			rd_addr_reg  <= `BL_FMT_ADDR;
			a24_reg      <= 1'b0;
			cont_low_reg <= 1'b1;
			hi_reg       <= 1'b0;
			lo_reg       <= 8'h00;
			wcnt_reg     <= 2'h0;
			words_reg    <= 16'h0000;
			dest_reg     <= 16'h0000;
			csum_reg     <= 16'h0000;
			trl0_reg     <= 16'h0000;
			ram_we       <= 1'b0;
			ram_addr     <= 16'h0000;
			ram_wdata    <= 16'h0000;
			app_start    <= 1'b0;
			app_addr     <= 16'h0000;
			ovl_done     <= 1'b0;
			load_error   <= 1'b0;
			deep_sleep   <= 1'b0;
		end else begin
			spi.start <= 1'b0;
			ram_we    <= 1'b0;
			app_start <= 1'b0;
			ovl_done  <= 1'b0;
			unique case (state_reg)
				bl_pkg::ST_SUC: begin
					if (suc_done) begin
						if (dbg_locked && dbg_pw_valid) begin
							state_reg  <= bl_pkg::ST_SLEEP;
						end else if (suc_ok) begin
							state_reg  <= bl_pkg::ST_VEC;
						end else begin
							load_error <= 1'b1;
							state_reg  <= bl_pkg::ST_SLEEP;
						end
					end
				end
				bl_pkg::ST_VEC: begin
					loader_entry <= rom_data;
					boost_en_reg <= 1'b1;
					tmr_reg      <= 32'h0;
					state_reg    <= bl_pkg::ST_WAIT;
				end
				bl_pkg::ST_WAIT: begin
					if (tmr_reg == 32'(WAIT_CYC - 1)) begin
						state_reg   <= bl_pkg::ST_CMD;
						rd_addr_reg <= `BL_FMT_ADDR;
						phase_reg   <= bl_pkg::PH_FMT;
						idx_reg     <= 3'h0;
					end else begin
						tmr_reg <= tmr_reg + 32'h1;
					end
				end
				bl_pkg::ST_CMD: begin
					if (!wait_ans_reg) begin
						spi_cs_n     <= 1'b0;
						spi.start    <= 1'b1;
						spi.tx       <= cmd_byte(idx_reg, rd_addr_reg, a24_reg);
						wait_ans_reg <= 1'b1;
					end else if (spi.done) begin
						wait_ans_reg <= 1'b0;
						if (idx_reg == (a24_reg ? 3'h3 : 3'h2)) begin
							state_reg <= bl_pkg::ST_DATA;
							hi_reg    <= 1'b0;
							wcnt_reg  <= 2'h0;
							csum_reg  <= 16'h0000;
						end else begin
							idx_reg <= idx_reg + 3'h1;
						end
					end
				end
				bl_pkg::ST_DATA: begin
					if (!wait_ans_reg) begin
						spi.start    <= 1'b1;
						spi.tx       <= 8'h00;
						wait_ans_reg <= 1'b1;
					end else if (spi.done) begin
						wait_ans_reg <= 1'b0;
						hi_reg       <= ~hi_reg;
						if (!hi_reg) begin
							lo_reg <= spi.rx;
						end else begin
							unique case (phase_reg)
								bl_pkg::PH_FMT: begin
									spi_cs_n     <= 1'b1;
									idx_reg      <= 3'h0;
									rd_addr_reg  <= `BL_BOOT_ADDR;
									cont_low_reg <= 1'b1;
									phase_reg    <= bl_pkg::PH_HDR;
									if (word == `BL_FMT_A16 || word == `BL_FMT_A24) begin
										a24_reg   <= (word == `BL_FMT_A24);
										state_reg <= bl_pkg::ST_CMD;
									end else begin
										state_reg <= bl_pkg::ST_END;
										load_error <= 1'b1;
									end
								end
								bl_pkg::PH_HDR: begin
									csum_reg <= csum_reg ^ word;
									wcnt_reg <= wcnt_reg + 2'h1;
									if (wcnt_reg == 2'h0) begin
										words_reg <= {1'b0, word[15:1]} + {15'h0, word[0]};
									end else if (wcnt_reg == 2'h1) begin
										dest_reg  <= word;
									end else begin
										app_addr  <= word;
										wcnt_reg  <= 2'h0;
										phase_reg <= (words_reg == 16'h0000) ?
											bl_pkg::PH_TRL : bl_pkg::PH_PAY;
									end
								end
								bl_pkg::PH_PAY: begin
									csum_reg  <= csum_reg ^ word;
									ram_we    <= 1'b1;
									ram_addr  <= dest_reg;
									ram_wdata <= word;
									dest_reg  <= dest_reg + 16'h0002;
									words_reg <= words_reg - 16'h0001;
									if (words_reg == 16'h0001) begin
										phase_reg <= bl_pkg::PH_TRL;
									end
								end
								bl_pkg::PH_TRL: begin
									if (wcnt_reg == 2'h0) begin
										trl0_reg <= word;
										wcnt_reg <= 2'h1;
									end else begin
										spi_cs_n   <= 1'b1;
										state_reg  <= bl_pkg::ST_END;
										load_error <= !(trl0_reg == csum_reg && word == csum_reg);
									end
								end
							endcase
						end
					end
				end
				bl_pkg::ST_END: begin
					spi_cs_n <= 1'b1;
					tmr_reg  <= 32'h0;
					if (load_error) begin
						boost_en_reg <= 1'b0;
						blink_reg    <= 3'h0;
						state_reg    <= bl_pkg::ST_BLINK;
					end else if (cont_low_reg) begin
						boost_en_reg <= 1'b0;
						if (dbg_locked && dbg_pw_valid) begin
							state_reg <= bl_pkg::ST_SLEEP;
						end else begin
							app_start <= 1'b1;
							state_reg <= bl_pkg::ST_RUN;
						end
					end else begin
						ovl_done  <= 1'b1;
						state_reg <= bl_pkg::ST_RUN;
					end
				end
				bl_pkg::ST_RUN: begin
					if (ovl_req) begin
						rd_addr_reg  <= ovl_addr;
						cont_low_reg <= (ovl_addr < `BL_OVL_BASE);
						phase_reg    <= bl_pkg::PH_HDR;
						idx_reg      <= 3'h0;
						state_reg    <= bl_pkg::ST_CMD;
					end
				end
				bl_pkg::ST_BLINK: begin
					if (tmr_reg == 32'(BLINK_CYC - 1)) begin
						tmr_reg   <= 32'h0;
						blink_reg <= blink_reg + 3'h1;
						if (blink_reg == 3'(2 * `BL_BLINK_COUNT)) begin
							state_reg <= bl_pkg::ST_SLEEP;
						end
					end else begin
						tmr_reg <= tmr_reg + 32'h1;
					end
				end
				bl_pkg::ST_SLEEP: begin
					deep_sleep   <= 1'b1;
					boost_en_reg <= 1'b0;
					spi_cs_n     <= 1'b1;
				end
				default: begin
					state_reg <= bl_pkg::ST_SLEEP;
				end
			endcase
		end
	end
endmodule // bl_boot_loader
`default_nettype wire

// ==== bench/bl_boot_loader_props.sv ====
// Purpose: Port-level properties of the serial-memory boot loader.
// Assumes: One core_clk domain; resetn is active low.
// Notes:   Bound to every instance of the loader.
`timescale 1ns/10ps
`default_nettype none
module bl_boot_loader_props #(
	parameter int WAIT_CYC  = 200,
	parameter int BLINK_CYC = 50
) (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [15:0] rom_addr,
	input wire logic        boost_clk,
	input wire logic        led_on,
	input wire logic        spi_cs_n,
	input wire logic        spi_sclk,
	input wire logic        spi_mosi,
	input wire logic        ram_we,
	input wire logic        app_start,
	input wire logic        load_error,
	input wire logic        deep_sleep
);
	logic [7:0]  half_reg;
	logic [15:0] lit_reg;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Cycles since the boost clock last changed, and cycles the LED supply has been on.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			half_reg <= 8'h00;
			lit_reg  <= 16'h0000;
		end else begin
			half_reg <= $changed(boost_clk) ? 8'h00 : half_reg + 8'h01;
			lit_reg  <= (led_on && lit_reg != 16'hffff) ? lit_reg + 16'h0001 : lit_reg;
		end
	end

	sequence s_high_half;
		spi_sclk [*4];
	endsequence

	property p_rom_vec; rom_addr == 16'hf840; endproperty
	a_rom_vec: assert property (p_rom_vec) else $error("vector address wrong");
	property p_boost_half; $fell(boost_clk) && led_on |-> (half_reg == 8'h63) or (##1 !led_on);
	endproperty
	a_boost_half: assert property (p_boost_half) else $error("boost half period");
	property p_wait; $fell(spi_cs_n) |-> lit_reg >= WAIT_CYC - 4; endproperty
	a_wait: assert property (p_wait) else $error("frame before supply wait");
	property p_cs_idle; spi_cs_n |-> !spi_sclk; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("clock while deselected");
	property p_sclk_half; $rose(spi_sclk) |-> s_high_half ##1 !spi_sclk; endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("serial clock high phase");
	property p_mosi_hold; !spi_cs_n && spi_sclk |-> $stable(spi_mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
	property p_ram_frame; ram_we |-> !spi_cs_n ##1 !ram_we; endproperty
	a_ram_frame: assert property (p_ram_frame) else $error("RAM write outside frame");
	property p_app_end; app_start |-> !load_error && !deep_sleep ##1 !app_start && spi_cs_n;
	endproperty
	a_app_end: assert property (p_app_end) else $error("bad application start");
	property p_err_hold; load_error |=> load_error && !app_start; endproperty
	a_err_hold: assert property (p_err_hold) else $error("error not held");
	property p_sleep; deep_sleep |=> deep_sleep && !app_start && spi_cs_n; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep left");
endmodule // bl_boot_loader_props

bind bl_boot_loader bl_boot_loader_props #(.WAIT_CYC(WAIT_CYC), .BLINK_CYC(BLINK_CYC))
	i_bl_boot_loader_props (.core_clk, .resetn, .rom_addr, .boost_clk, .led_on, .spi_cs_n,
	.spi_sclk, .spi_mosi, .ram_we, .app_start, .load_error, .deep_sleep);
`default_nettype wire

// ==== bench/bl_spi_mem.sv ====
// Purpose: Behavioural one-bit serial memory answering read frames.
// Assumes: Mode 0 link; the loader owns select and clock.
// Notes:   The first frame after a loader reset carries a 16-bit address.
`timescale 1ns/10ps
`default_nettype none
module bl_spi_mem (
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic mosi,
	input  wire logic aw24,
	output var logic  miso
);
	logic [7:0]  mem [0:4095];
	logic [7:0]  cmd;
	logic [23:0] addr;
	logic        first;
	int          nbit, hdr, a;

	initial begin
		miso = 1'b0;
		first = 1'b1;
		foreach (mem[i]) mem[i] = 8'hff;
	end

	always @(negedge cs_n) begin
		nbit = 0;
		addr = 24'h000000;
		hdr = (first || !aw24) ? 24 : 32;
	end

	always @(posedge cs_n) begin
		first = 1'b0;
		miso = ~miso;
	end

	always @(posedge sclk) begin
		if (!cs_n) begin
			if (nbit < 8) cmd = {cmd[6:0], mosi};
			else if (nbit < hdr) addr = {addr[22:0], mosi};
			nbit++;
		end
	end

	// Outside the data phase the line wanders so that no stale bit looks valid.
	always @(negedge sclk) begin
		a = int'(addr) + (nbit - hdr) / 8;
		if (!cs_n && cmd == 8'h03 && nbit >= hdr) begin
			miso = mem[a[11:0]][7 - (nbit - hdr) % 8];
		end else begin
			miso = ~miso;
		end
	end
endmodule // bl_spi_mem
`default_nettype wire

// ==== bench/tb_spi_memory_boot_loader.sv ====
// Purpose: Self-checking bench of the serial-memory boot loader.
// Assumes: 50 MHz core clock; shortened wait and blink counts.
// Notes:   Images are built here; every RAM write is checked against them.
`timescale 1ns/10ps
`default_nettype none
module tb_spi_memory_boot_loader;
	logic        core_clk, resetn, suc_done, suc_ok, dbg_locked, dbg_pw_valid, aw24, led_d;
	logic [15:0] rom_addr, rom_data, loader_entry, ram_addr, ram_wdata, app_addr, exp_start;
	logic        boost_clk, led_on, spi_cs_n, spi_sclk, spi_mosi, spi_miso, ram_we;
	logic        ovl_req, app_start, ovl_done, load_error, deep_sleep;
	logic [23:0] ovl_addr;
	logic [31:0] exp_q[$];
	int          miscompares, comparisons, blinks;

	bl_boot_loader #(.WAIT_CYC(200), .BLINK_CYC(50)) i_bl_boot_loader (.core_clk, .resetn,
		.suc_done, .suc_ok, .dbg_locked, .dbg_pw_valid, .rom_addr, .rom_data, .loader_entry,
		.boost_clk, .led_on, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso, .ram_we, .ram_addr,
		.ram_wdata, .ovl_req, .ovl_addr, .app_start, .app_addr, .ovl_done, .load_error,
		.deep_sleep);
	bl_spi_mem i_bl_spi_mem (.cs_n(spi_cs_n), .sclk(spi_sclk), .mosi(spi_mosi), .aw24,
		.miso(spi_miso));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Outputs are looked at mid-cycle, where they have settled.
	always @(negedge core_clk) begin
		led_d <= led_on;
		if (load_error === 1'b1 && led_on === 1'b1 && led_d !== 1'b1) blinks++;
		if (ram_we === 1'b1) begin
			chk({ram_addr, ram_wdata}, exp_q.size() ? exp_q.pop_front() : 'x);
		end
	end

	task automatic wr16(input int a, input logic [15:0] w);
		i_bl_spi_mem.mem[a] = w[7:0];
		i_bl_spi_mem.mem[a + 1] = w[15:8];
	endtask

	// Odd length, so the last payload word carries one zero pad byte.
	task automatic box(input int a, input int n, input bit bad);
		logic [15:0] ck, w, d;
		d = 16'h0200 + 16'($urandom_range(0, 255)) * 16'h0002;
		exp_start = 16'($urandom);
		ck = 16'(2 * n - 1) ^ d ^ exp_start;
		wr16(a, 16'(2 * n - 1));
		wr16(a + 2, d);
		wr16(a + 4, exp_start);
		for (int i = 0; i < n; i++) begin
			w = 16'($urandom);
			if (i == n - 1) w[15:8] = 8'h00;
			wr16(a + 6 + 2 * i, w);
			ck ^= w;
			exp_q.push_back({d + 16'(2 * i), w});
		end
		wr16(a + 6 + 2 * n, ck);
		wr16(a + 8 + 2 * n, bad ? ~ck : ck);
	endtask

	task automatic scen(input bit a24, input logic [15:0] fmt, input bit bad, lk, ok);
		bit app;
		bit good;
		good = ok && !lk && !bad && (fmt == 16'h0010 || fmt == 16'h0018);
		@(posedge core_clk);
		resetn <= 1'b0;
		suc_done <= 1'b0;
		suc_ok <= ok;
		dbg_locked <= lk;
		dbg_pw_valid <= lk;
		aw24 <= a24;
		rom_data <= 16'($urandom);
		exp_q.delete();
		i_bl_spi_mem.first = 1'b1;
		wr16(0, fmt);
		box(2, 3 + a24, bad);
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		suc_done <= 1'b1;
		blinks = 0;
		app = 1'b0;
		for (int i = 0; i < 6000 && !app && deep_sleep !== 1'b1; i++) begin
			@(negedge core_clk);
			app = app_start === 1'b1;
		end
		chk({app, deep_sleep, load_error}, {good, !good, !good && !lk});
		chk(spi_cs_n, 1'b1);
		if (good) begin
			chk({app_addr, loader_entry}, {exp_start, rom_data});
			chk(40'(exp_q.size()), 40'h0);
			repeat (2) @(negedge core_clk);
			chk(led_on, 1'b0);
		end else if (ok) begin
			chk(40'(blinks), lk ? 40'h0 : 40'h3);
		end
		$display("test done: format %h fault %0d locked %0d startup %0d", fmt, bad, lk, ok);
	endtask

	initial begin
		resetn = 1'b0;
		{suc_done, suc_ok, dbg_locked, dbg_pw_valid, ovl_req, aw24} = 6'h00;
		rom_data = 16'h0000;
		ovl_addr = 24'h000000;
		void'($urandom(16));
		scen(1'b0, 16'h0010, 1'b0, 1'b0, 1'b1);
		box(32'h800, 4, 1'b0);
		@(posedge core_clk);
		ovl_addr <= 24'h000800;
		ovl_req <= 1'b1;
		@(posedge core_clk);
		ovl_req <= 1'b0;
		for (int i = 0; i < 4000 && ovl_done !== 1'b1; i++) @(negedge core_clk);
		chk({ovl_done, led_on, app_addr}, {2'b10, exp_start});
		chk(40'(exp_q.size()), 40'h0);
		$display("test done: overlay at upper region");
		scen(1'b1, 16'h0018, 1'b0, 1'b0, 1'b1);
		scen(1'b0, 16'h0010, 1'b1, 1'b0, 1'b1);
		scen(1'b0, 16'hffff, 1'b0, 1'b0, 1'b1);
		scen(1'b0, 16'h0010, 1'b0, 1'b1, 1'b1);
		scen(1'b0, 16'h0010, 1'b0, 1'b0, 1'b0);
		results();
	end

	initial begin
		#2000000;
		miscompares++;
		results();
	end
endmodule // tb_spi_memory_boot_loader
`default_nettype wire
